// ### rtl/input_function_decoder.sv
// Input function decoder: maps each input terminal to a drive control function.
// Assumes terminal pins are already synchronous to sys_clk and filtered upstream.
//
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`include "input_function_decoder_map.svh"
`default_nettype none

module input_function_decoder
   import input_function_decoder_pkg::*;
(
   input  wire logic          sys_clk,
   input  wire logic          arst_n,
   input  wire logic [5:0]    address,
   input  wire logic          read,
   input  wire logic          write,
   input  wire logic [3:0]    byteenable,
   input  wire logic [31:0]   writedata,
   output logic      [31:0]   readdata,
   output logic               waitrequest,
   input  wire logic [3:0]    inputTerminal,
   input  wire logic [5:0]    outputStateIn,
   output logic      [5:0]    outputForceValue,
   output logic      [2:0]    outputLevelSelect,
   output ctl_s               ctlOut,
   output evt_s               evtOut
);

   // ----------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------
   bus_state_e   busState_ff;
   code_t        funcCode_ff [NumTerm];
   logic [3:0]   polarity_ff;
   logic [5:0]   outForce_ff;
   logic [2:0]   outLevel_ff;
   logic [31:0]  readdata_ff;
   logic [31:0]  funcState_ff;
   logic [31:0]  prevState_ff;
   logic [31:0]  rise_ff;
   logic [31:0]  fall_ff;
   logic [31:0]  nxt_funcState;
   logic [3:0]   termEff;
   logic [31:0]  nxt_readdata;
   logic         busReq;
   logic         wrTake;

   assign busReq      = read | write;
   // One wait cycle lets read data settle in a flop before the master takes it.
   assign waitrequest = busReq & (busState_ff == BUS_IDLE);
   assign wrTake      = write & (busState_ff == BUS_ACK) & byteenable[0];
   assign readdata    = readdata_ff;

   // Bus handshake state.
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         busState_ff <= BUS_IDLE;
      else
      begin
         unique case (busState_ff)
            BUS_IDLE: if (busReq) busState_ff <= BUS_ACK;
            BUS_ACK:  busState_ff <= BUS_IDLE;
            default:  busState_ff <= BUS_IDLE;
         endcase
      end
   end

   // Configuration writes; unmapped addresses are ignored.
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (int i = 0; i < NumTerm; i++)
            funcCode_ff[i] <= `IFD_RST_FUNC;
         polarity_ff <= `IFD_RST_POLARITY;
         outForce_ff <= `IFD_RST_OUTFORCE;
         outLevel_ff <= `IFD_RST_OUTLEVEL;
      end
      else if (wrTake)
      begin
         unique case (address)
            `IFD_OFS_FUNC0:    funcCode_ff[0] <= writedata[CodeW-1:0];
            `IFD_OFS_FUNC1:    funcCode_ff[1] <= writedata[CodeW-1:0];
            `IFD_OFS_FUNC2:    funcCode_ff[2] <= writedata[CodeW-1:0];
            `IFD_OFS_FUNC3:    funcCode_ff[3] <= writedata[CodeW-1:0];
            `IFD_OFS_POLARITY: polarity_ff    <= writedata[3:0];
            `IFD_OFS_OUTFORCE: outForce_ff    <= writedata[5:0];
            `IFD_OFS_OUTLEVEL: outLevel_ff    <= writedata[2:0];
            default: ;
         endcase
      end
   end

   // Read mux; unmapped addresses read as zero.
   always_comb
   begin
      nxt_readdata = 32'h0000_0000;
      unique case (address)
         `IFD_OFS_FUNC0:    nxt_readdata = {25'h0, funcCode_ff[0]};
         `IFD_OFS_FUNC1:    nxt_readdata = {25'h0, funcCode_ff[1]};
         `IFD_OFS_FUNC2:    nxt_readdata = {25'h0, funcCode_ff[2]};
         `IFD_OFS_FUNC3:    nxt_readdata = {25'h0, funcCode_ff[3]};
         `IFD_OFS_POLARITY: nxt_readdata = {28'h0, polarity_ff};
         `IFD_OFS_MONITOR:  nxt_readdata = funcState_ff;
         `IFD_OFS_OUTSTATE: nxt_readdata = {26'h0, outputStateIn};
         `IFD_OFS_OUTFORCE: nxt_readdata = {26'h0, outForce_ff};
         `IFD_OFS_OUTLEVEL: nxt_readdata = {29'h0, outLevel_ff};
         default:           nxt_readdata = 32'h0000_0000;
      endcase
   end

   // Read data is captured in the wait cycle and stands at the ack edge.
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         readdata_ff <= 32'h0000_0000;
      else if (read && busState_ff == BUS_IDLE)
         readdata_ff <= nxt_readdata;
   end

   assign outputForceValue  = outForce_ff;
   assign outputLevelSelect = outLevel_ff;

   // ----------------------------------------------------------------
   // Function decode
   // ----------------------------------------------------------------
   // Effective state: pin equal to its polarity bit counts as active.
   always_comb
   begin
      for (int i = 0; i < NumTerm; i++)
         termEff[i] = ~(inputTerminal[i] ^ polarity_ff[i]);
   end

   // Codes above 31 have no monitor bit and no effect here.
   always_comb
   begin
      nxt_funcState = 32'h0000_0000;
      for (int i = 0; i < NumTerm; i++)
      begin
         if (termEff[i] && funcCode_ff[i] < 7'h20)
            nxt_funcState[funcCode_ff[i][4:0]] = 1'b1;
      end
      nxt_funcState[`IFD_FC_NONE] = 1'b0;
   end

   // Function state, previous state and edge pulses.
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         funcState_ff <= 32'h0000_0000;
         prevState_ff <= 32'h0000_0000;
         rise_ff      <= 32'h0000_0000;
         fall_ff      <= 32'h0000_0000;
      end
      else
      begin
         funcState_ff <= nxt_funcState;
         prevState_ff <= funcState_ff;
         rise_ff      <= funcState_ff & ~prevState_ff;
         fall_ff      <= ~funcState_ff & prevState_ff;
      end
   end

   // ----------------------------------------------------------------
   // Outputs to motion and control logic
   // ----------------------------------------------------------------
   // Level functions follow the registered function state, one cycle behind the effective state.
   always_comb
   begin
      ctlOut.driveEnable    = funcState_ff[`IFD_FC_ENABLE];
      ctlOut.torqueSrcB     = funcState_ff[`IFD_FC_TRQSRCB];
      ctlOut.torqueInvert   = funcState_ff[`IFD_FC_TRQINV];
      ctlOut.fwdTorqueLimit = funcState_ff[`IFD_FC_FWDTRQLIM];
      ctlOut.revTorqueLimit = funcState_ff[`IFD_FC_REVTRQLIM];
      ctlOut.fwdSpeedLimit  = funcState_ff[`IFD_FC_FWDSPDLIM];
      ctlOut.revSpeedLimit  = funcState_ff[`IFD_FC_REVSPDLIM];
      ctlOut.jogFwd         = funcState_ff[`IFD_FC_JOGFWD];
      ctlOut.jogRev         = funcState_ff[`IFD_FC_JOGREV];
      ctlOut.speedRefInvert = funcState_ff[`IFD_FC_SPDREFINV];
      ctlOut.mainSpeedB     = funcState_ff[`IFD_FC_MAINSPDB];
      ctlOut.speedStop      = funcState_ff[`IFD_FC_SPDSTOP];
      ctlOut.zeroClamp      = funcState_ff[`IFD_FC_ZEROCLAMP];
      ctlOut.multiSpeedBit0 = funcState_ff[`IFD_FC_MSPDBIT0];
   end

   // Edge functions fire once per rising transition (msegStop once per falling one), never while held.
   always_comb
   begin
      evtOut.driveReset = rise_ff[`IFD_FC_DRVRESET];
      evtOut.fwReset    = rise_ff[`IFD_FC_FWRESET];
      evtOut.encClear   = rise_ff[`IFD_FC_ENCCLEAR];
      evtOut.msegStart  = rise_ff[`IFD_FC_MSEGTRIG];
      evtOut.msegStop   = fall_ff[`IFD_FC_MSEGTRIG];
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_code0_none;
      @(posedge sys_clk) disable iff (!arst_n)
      funcState_ff[0] == 1'b0;
   endproperty
   a_code0_none: assert property (p_code0_none)
      else $error("Code zero produced a function state.");

   property p_enable_follow;
      @(posedge sys_clk) disable iff (!arst_n)
      (termEff[0] && funcCode_ff[0] == 7'h01) |=> ctlOut.driveEnable;
   endproperty
   a_enable_follow: assert property (p_enable_follow)
      else $error("Drive enable missing after active terminal.");

   property p_rst_edge;
      @(posedge sys_clk) disable iff (!arst_n)
      $rose(funcState_ff[2]) |=> evtOut.driveReset ##1 !evtOut.driveReset;
   endproperty
   a_rst_edge: assert property (p_rst_edge)
      else $error("Drive reset pulse wrong after rising edge.");

   property p_enc_once;
      @(posedge sys_clk) disable iff (!arst_n)
      (funcState_ff[15] && $past(funcState_ff[15])) |=> !evtOut.encClear;
   endproperty
   a_enc_once: assert property (p_enc_once)
      else $error("Encoder clear repeated while held.");

   property p_torque_or;
      @(posedge sys_clk) disable iff (!arst_n)
      ((termEff[0] && funcCode_ff[0] == 7'h05) || (termEff[1] && funcCode_ff[1] == 7'h05))
      |=> ctlOut.fwdTorqueLimit;
   endproperty
   a_torque_or: assert property (p_torque_or)
      else $error("Shared code did not OR terminals.");

   property p_pol_low;
      @(posedge sys_clk) disable iff (!arst_n)
      (!polarity_ff[2] && !inputTerminal[2] && funcCode_ff[2] == 7'h0D) |=> ctlOut.speedStop;
   endproperty
   a_pol_low: assert property (p_pol_low)
      else $error("Active-low terminal not seen as effective.");

   property p_mseg_stop;
      @(posedge sys_clk) disable iff (!arst_n)
      $fell(funcState_ff[27]) |=> evtOut.msegStop && !evtOut.msegStart;
   endproperty
   a_mseg_stop: assert property (p_mseg_stop)
      else $error("Multi-segment stop missing after fall.");

   property p_pulse_single;
      @(posedge sys_clk) disable iff (!arst_n)
      evtOut.fwReset |=> !evtOut.fwReset;
   endproperty
   a_pulse_single: assert property (p_pulse_single)
      else $error("Edge pulse lasted more than one cycle.");

   property p_monitor_read;
      @(posedge sys_clk) disable iff (!arst_n)
      (read && !waitrequest && address == `IFD_OFS_MONITOR) |-> readdata == $past(funcState_ff);
   endproperty
   a_monitor_read: assert property (p_monitor_read)
      else $error("Monitor read does not show function state.");

   property p_bus_one_wait;
      @(posedge sys_clk) disable iff (!arst_n)
      (busReq && waitrequest) |=> !waitrequest;
   endproperty
   a_bus_one_wait: assert property (p_bus_one_wait)
      else $error("Bus request waited more than one cycle.");

   property p_jog_hold;
      @(posedge sys_clk) disable iff (!arst_n)
      (termEff[0] && funcCode_ff[0] == 7'h0A) |=> ctlOut.jogRev;
   endproperty
   a_jog_hold: assert property (p_jog_hold)
      else $error("Reverse jog missing while terminal held.");

   property p_mspd_follow;
      @(posedge sys_clk) disable iff (!arst_n)
      (termEff[0] && funcCode_ff[0] == 7'h11) |=> ctlOut.multiSpeedBit0;
   endproperty
   a_mspd_follow: assert property (p_mspd_follow)
      else $error("Multi-speed bit missing while terminal held.");

   c_enable: cover property (@(posedge sys_clk) disable iff (!arst_n) ctlOut.driveEnable);
   c_enc: cover property (@(posedge sys_clk) disable iff (!arst_n) evtOut.encClear);
   c_mseg: cover property (@(posedge sys_clk) disable iff (!arst_n) evtOut.msegStop);
   c_write: cover property (@(posedge sys_clk) disable iff (!arst_n) wrTake);
   c_fwreset: cover property (@(posedge sys_clk) disable iff (!arst_n) evtOut.fwReset);

endmodule : input_function_decoder
`default_nettype wire

// ### pkg/input_function_decoder_map.svh
// Register offsets, reset values and function codes of the input decoder.
// Assumes a 32-bit Avalon-MM slave with byte addresses.
`ifndef INPUT_FUNCTION_DECODER_MAP_SVH
`define INPUT_FUNCTION_DECODER_MAP_SVH
`define IFD_OFS_FUNC0     6'h00
`define IFD_OFS_FUNC1     6'h04
`define IFD_OFS_FUNC2     6'h08
`define IFD_OFS_FUNC3     6'h0C
`define IFD_OFS_POLARITY  6'h10
`define IFD_OFS_MONITOR   6'h14
`define IFD_OFS_OUTSTATE  6'h18
`define IFD_OFS_OUTFORCE  6'h1C
`define IFD_OFS_OUTLEVEL  6'h20
`define IFD_RST_FUNC      7'h00
`define IFD_RST_POLARITY  4'h0
`define IFD_RST_OUTFORCE  6'h00
`define IFD_RST_OUTLEVEL  3'h0
`define IFD_FC_NONE       0
`define IFD_FC_ENABLE     1
`define IFD_FC_DRVRESET   2
`define IFD_FC_TRQSRCB    3
`define IFD_FC_TRQINV     4
`define IFD_FC_FWDTRQLIM  5
`define IFD_FC_REVTRQLIM  6
`define IFD_FC_FWDSPDLIM  7
`define IFD_FC_REVSPDLIM  8
`define IFD_FC_JOGFWD     9
`define IFD_FC_JOGREV     10
`define IFD_FC_SPDREFINV  11
`define IFD_FC_MAINSPDB   12
`define IFD_FC_SPDSTOP    13
`define IFD_FC_FWRESET    14
`define IFD_FC_ENCCLEAR   15
`define IFD_FC_ZEROCLAMP  16
`define IFD_FC_MSPDBIT0   17
`define IFD_FC_MSEGTRIG   27
`endif

// ### pkg/input_function_decoder_pkg.sv
// Types shared by the input function decoder and its bench.
// Assumes the map header is on the include path.
`default_nettype none
package input_function_decoder_pkg;
   localparam int NumTerm = 4;
   localparam int CodeW   = 7;
   typedef logic [CodeW-1:0] code_t;
   typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_ACK = 2'b10} bus_state_e;
   typedef struct packed {
      logic driveEnable;
      logic torqueSrcB;
      logic torqueInvert;
      logic fwdTorqueLimit;
      logic revTorqueLimit;
      logic fwdSpeedLimit;
      logic revSpeedLimit;
      logic jogFwd;
      logic jogRev;
      logic speedRefInvert;
      logic mainSpeedB;
      logic speedStop;
      logic zeroClamp;
      logic multiSpeedBit0;
   } ctl_s;
   typedef struct packed {
      logic driveReset;
      logic fwReset;
      logic encClear;
      logic msegStart;
      logic msegStop;
   } evt_s;
endpackage : input_function_decoder_pkg
`default_nettype wire

// ### test/switch_bank.sv
// Model of the switches and controller lines wired to the input terminals.
// Assumes the bench sets which contacts are closed and how each is wired.
`default_nettype none

module switch_bank
(
   input  wire logic       sys_clk,
   input  wire logic [3:0] swOn,
   input  wire logic [3:0] swPol,
   output logic      [3:0] pinOut
);
   timeunit 1ns;
   timeprecision 1ps;

   //---------------------------------------------------------------
   // Contact levels
   //---------------------------------------------------------------
   // A closed contact shows the level that the terminal's polarity names as active.
   // Pins hold no value until the first edge, which falls well inside reset.
   // The pin moves on a clock edge, so the decoder never sees it change mid-cycle.
   always @(posedge sys_clk)
   begin
      pinOut <= ~(swOn ^ swPol);
   end
endmodule : switch_bank
`default_nettype wire

// ### test/input_function_decoder_test.sv
// Self-checking bench for the input function decoder.
// Assumes the switch model drives the terminals and the bench is the bus master.
`include "input_function_decoder_map.svh"
`default_nettype none

module input_function_decoder_test
   import input_function_decoder_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   //---------------------------------------------------------------
   // Signals, clock and instances
   //---------------------------------------------------------------
   logic        sys_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [5:0]  address = 6'h00;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [3:0]  byteenable = 4'h0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic        waitrequest;
   logic [3:0]  pins;
   logic [3:0]  swOn = 4'h0;
   logic [3:0]  swPol = 4'h0;
   logic [5:0]  outputStateIn = 6'h00;
   logic [5:0]  outputForceValue;
   logic [2:0]  outputLevelSelect;
   ctl_s        ctlOut;
   evt_s        evtOut;
   int          numErrors = 0;
   int          checksDone = 0;
   int          lvl [14] = '{1, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 16, 17};
   int          edg [4] = '{2, 14, 15, 27};
   logic [4:0]  onVec [4] = '{5'h10, 5'h08, 5'h04, 5'h02};

   always #2 sys_clk = ~sys_clk;

   switch_bank sw (.sys_clk(sys_clk), .swOn(swOn), .swPol(swPol), .pinOut(pins));

   input_function_decoder dut (.sys_clk(sys_clk), .arst_n(arst_n), .address(address),
      .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .inputTerminal(pins),
      .outputStateIn(outputStateIn), .outputForceValue(outputForceValue),
      .outputLevelSelect(outputLevelSelect), .ctlOut(ctlOut), .evtOut(evtOut));

   //---------------------------------------------------------------
   // Tasks
   //---------------------------------------------------------------
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checksDone, numErrors);
      if (numErrors == 0 && checksDone > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checksDone++;
      if (got !== exp)
      begin
         numErrors++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // Waitrequest and read data are taken at the rising edge where waitrequest is low; the
   // request is released by non-blocking assignment at that same edge, after sampling.
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
      int   n;
      logic done;
      done = 1'b0;
      q = 32'h0;
      @(posedge sys_clk);
      address <= a;
      writedata <= d;
      byteenable <= be;
      write <= wr;
      read <= ~wr;
      for (n = 0; n < 16 && !done; n++)
      begin
         @(posedge sys_clk);
         if (waitrequest === 1'b0)
         begin
            done = 1'b1;
            q = readdata;
         end
      end
      read <= 1'b0;
      write <= 1'b0;
      if (!done)
      begin
         chk("bus answer", 32'h0, 32'h1);
         wrap_up();
      end
   endtask : bus

   task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
      logic [31:0] q;
      bus(1'b1, a, d, be, q);
   endtask : wr

   task automatic rdChk(input string nm, input logic [5:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, 4'hF, q);
      chk(nm, exp, q);
   endtask : rdChk

   // Counts pulses over a window: the wanted pulse exactly once, nothing else at all.
   task automatic evtWin(input string nm, input logic [4:0] exp);
      int hit;
      int bad;
      hit = 0;
      bad = 0;
      repeat (10)
      begin
         @(negedge sys_clk);
         if (exp !== 5'h00 && evtOut === exp)
            hit++;
         else if (evtOut !== 5'h00)
            bad++;
      end
      chk(nm, (exp !== 5'h00) ? 32'h1 : 32'h0, hit);
      chk(nm, 32'h0, bad);
      @(posedge sys_clk);
   endtask : evtWin

   //---------------------------------------------------------------
   // Test sequence
   //---------------------------------------------------------------
   initial
   begin
      repeat (12) @(posedge sys_clk);
      arst_n <= 1'b1;
      rdChk("polarity", `IFD_OFS_POLARITY, 32'h0);
      rdChk("func0", `IFD_OFS_FUNC0, 32'h0);
      rdChk("outforce", `IFD_OFS_OUTFORCE, 32'h0);
      rdChk("outlevel", `IFD_OFS_OUTLEVEL, 32'h0);
      $display("test reset values done");
      outputStateIn <= 6'h2D;
      wr(`IFD_OFS_OUTFORCE, 32'h2A, 4'hF);
      wr(`IFD_OFS_OUTLEVEL, 32'h5, 4'hF);
      wr(`IFD_OFS_OUTFORCE, 32'h3F, 4'hE);
      wr(6'h24, 32'hFF, 4'hF);
      chk("force pins", 32'h2A, outputForceValue);
      chk("level pins", 32'h5, outputLevelSelect);
      rdChk("outstate", `IFD_OFS_OUTSTATE, 32'h2D);
      rdChk("outforce", `IFD_OFS_OUTFORCE, 32'h2A);
      rdChk("unmapped", 6'h24, 32'h0);
      $display("test output registers done");
      swPol <= 4'h1;
      wr(`IFD_OFS_POLARITY, 32'h1, 4'hF);
      for (int i = 0; i < 14; i++)
      begin
         wr(`IFD_OFS_FUNC0, lvl[i], 4'hF);
         swOn <= 4'h1;
         repeat (4) @(posedge sys_clk);
         chk("ctl on", 32'h1 << (13 - i), ctlOut);
         rdChk("monitor", `IFD_OFS_MONITOR, 32'h1 << lvl[i]);
         swOn <= 4'h0;
         repeat (4) @(posedge sys_clk);
         chk("ctl off", 32'h0, ctlOut);
      end
      wr(`IFD_OFS_FUNC0, 32'h0, 4'hF);
      swOn <= 4'h1;
      repeat (4) @(posedge sys_clk);
      chk("code none", 32'h0, ctlOut);
      swOn <= 4'h0;
      $display("test level functions done");
      for (int i = 0; i < 4; i++)
      begin
         wr(`IFD_OFS_FUNC0, edg[i], 4'hF);
         swOn <= 4'h1;
         evtWin("edge on", onVec[i]);
         swOn <= 4'h0;
         evtWin("edge off", (i == 3) ? 5'h01 : 5'h00);
      end
      $display("test edge functions done");
      wr(`IFD_OFS_FUNC0, 32'hD, 4'hF);
      wr(`IFD_OFS_FUNC1, 32'hD, 4'hF);
      wr(`IFD_OFS_FUNC2, 32'hD, 4'hF);
      wr(`IFD_OFS_FUNC3, 32'hD, 4'hF);
      swPol <= 4'h0;
      wr(`IFD_OFS_POLARITY, 32'h0, 4'hF);
      repeat (4) @(posedge sys_clk);
      chk("or idle", 32'h0, ctlOut);
      swOn <= 4'h4;
      repeat (4) @(posedge sys_clk);
      chk("or one", 32'h4, ctlOut);
      swOn <= 4'hF;
      repeat (4) @(posedge sys_clk);
      chk("or all", 32'h4, ctlOut);
      swOn <= 4'h8;
      wr(`IFD_OFS_FUNC3, 32'h1F, 4'hF);
      rdChk("high code", `IFD_OFS_MONITOR, 32'h8000_0000);
      wr(`IFD_OFS_FUNC3, 32'h5F, 4'hF);
      rdChk("code over 31", `IFD_OFS_MONITOR, 32'h0);
      rdChk("func3", `IFD_OFS_FUNC3, 32'h5F);
      $display("test shared code done");
      wrap_up();
   end
endmodule : input_function_decoder_test
`default_nettype wire
